//--- src/swtc_defs.vh
/*
 Constants of the standby wake trigger block: register offsets, field
 positions, reset values and trigger codes.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef SWTC_DEFS_VH
`define SWTC_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define SWTC_OFF_MODE 4'h0
`define SWTC_OFF_CLEAR 4'h4
`define SWTC_OFF_STATUS 4'h8
`define SWTC_OFF_MASK 4'hC
`define SWTC_ADDR_W 4

// ----------------------------------------------------------------------
// Field layout of the mode register, one byte lane per source.
// ----------------------------------------------------------------------
`define SWTC_NSRC 4
`define SWTC_SEL_LSB 4
`define SWTC_EDGE_LSB 2
`define SWTC_EN_BIT 0
`define SWTC_LANE_W 8

// ----------------------------------------------------------------------
// Trigger codes and reset values.
// ----------------------------------------------------------------------
`define SWTC_TRIG_LOW 3'h0
`define SWTC_TRIG_HIGH 3'h1
`define SWTC_TRIG_FALL 3'h2
`define SWTC_TRIG_RISE 3'h3
`define SWTC_TRIG_BOTH 3'h4
`define SWTC_SEL_RST 3'h2
`define SWTC_EDGE_NONE 2'h0
`define SWTC_EDGE_RISE 2'h1
`define SWTC_EDGE_FALL 2'h2
`define SWTC_RESP_OKAY 2'h0
`define SWTC_RESP_SLVERR 2'h2
`define SWTC_ZERO32 32'h0000_0000

`endif

//--- src/swtc_source.v
/*
 One wake source: pin synchroniser, trigger matching and the record of
 the edge that released standby.
 Assumes the pin is asynchronous to clk and settings come from clk logic.
*/
`timescale 1ns/10ps
`include "swtc_defs.vh"

module swtc_source
(
   input wire clk,
   input wire reset,
   input wire pin,
   input wire [2:0] trigger_select,
   input wire wake_enable,
   input wire clear,
   output reg [1:0] detected_edge_q,
   output reg wake_q
);

   reg sync1_q;
   reg sync2_q;
   reg prev_q;
   reg match;
   wire rise;
   wire fall;

   // ----------------------------------------------------------------------
   // Synchroniser; only sync2_q and prev_q feed the edge logic.
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (reset)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;

   // Trigger match; prohibited codes never match, a safe choice.
   always @*
   begin
      case (trigger_select)
         `SWTC_TRIG_LOW: match = ~sync2_q;
         `SWTC_TRIG_HIGH: match = sync2_q;
         `SWTC_TRIG_FALL: match = fall;
         `SWTC_TRIG_RISE: match = rise;
         `SWTC_TRIG_BOTH: match = rise | fall;
         default: match = 1'b0;
      endcase
   end

   // Wake request is the enabled match one cycle later, a level in level modes; the edge record is sticky and an edge wins over clear.
   always @(posedge clk)
   begin
      if (reset)
      begin
         detected_edge_q <= `SWTC_EDGE_NONE;
         wake_q <= 1'b0;
      end
      else
      begin
         wake_q <= match & wake_enable;
         if (match & wake_enable & (trigger_select == `SWTC_TRIG_BOTH))
            detected_edge_q <= (clear ? `SWTC_EDGE_NONE : detected_edge_q)
               | (rise ? `SWTC_EDGE_RISE : `SWTC_EDGE_NONE)
               | (fall ? `SWTC_EDGE_FALL : `SWTC_EDGE_NONE);
         else if (clear)
            detected_edge_q <= `SWTC_EDGE_NONE;
      end
   end

endmodule // swtc_source

//--- src/swtc_top.v
/*
 Standby wake trigger configuration for external sources 4 to 7, with an
 AXI4-Lite register slave, sticky wake status and an interrupt output.
 Assumes one clock, synchronous active-high reset, asynchronous pins.
*/
// Behaviour
// - Source 7 trigger at bits 30-28: low, high, fall, rise, both.
// - Source 6 trigger at bits 22-20 with the same codes.
// - Source 5 trigger at bits 14-12 with the same codes.
// - Source 4 trigger at bits 6-4 with the same codes.
// - Source 7 edge record at bits 27-26: 01 rise, 10 fall, 11 both.
// - Edge records for sources 6, 5, 4 at bits 19-18, 11-10, 3-2.
// - Edge record is meaningful only in both-edge mode.
// - Edge record keeps which edge released standby.
// - Clearing a request also clears that source's edge record.
`timescale 1ns/10ps
`include "swtc_defs.vh"

module swtc_top
(
   input wire clk,
   input wire reset,
   input wire [3:0] ext_irq_pins,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [3:0] wake_request_q,
   output reg irq_q
);

   reg [2:0] sel_q [0:3];
   reg [3:0] en_q;
   reg [3:0] status_q;
   reg [3:0] mask_q;
   reg [3:0] aw_addr_q;
   reg aw_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_have_q;
   reg [31:0] mode_rd;
   reg [3:0] clear_d;
   wire [1:0] edge_rec [0:3];
   wire [3:0] wake;
   wire do_write;
   integer i;

   // Picks the trigger select field of lane n out of a written word.
   function [2:0] lane;
      input [31:0] data;
      input [1:0] n;
      begin
         lane = data[n*`SWTC_LANE_W + `SWTC_SEL_LSB +: 3];
      end
   endfunction

   // Tells whether an address names the given offset.
   function is_reg;
      input [3:0] addr;
      input [3:0] off;
      begin
         is_reg = (addr == off);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Per-source trigger logic, one lane per source.
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `SWTC_NSRC; g = g + 1)
      begin : gen_src
         swtc_source u_src
         (
            .clk(clk),
            .reset(reset),
            .pin(ext_irq_pins[g]),
            .trigger_select(sel_q[g]),
            .wake_enable(en_q[g]),
            .clear(clear_d[g]),
            .detected_edge_q(edge_rec[g]),
            .wake_q(wake[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Mode register read image: lanes for sources 4..7 at bytes 0..3.
   // ----------------------------------------------------------------------
   always @*
   begin
      mode_rd = `SWTC_ZERO32;
      for (i = 0; i < `SWTC_NSRC; i = i + 1)
      begin
         mode_rd[i*`SWTC_LANE_W + `SWTC_SEL_LSB +: 3] = sel_q[i];
         mode_rd[i*`SWTC_LANE_W + `SWTC_EDGE_LSB +: 2] = edge_rec[i];
         mode_rd[i*`SWTC_LANE_W + `SWTC_EN_BIT] = en_q[i];
      end
   end

   // A write happens once address and data are both held and no response is pending.
   assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

   // Clear register write: a one clears the pending request and its edge record.
   always @*
   begin
      clear_d = 4'h0;
      if (do_write && is_reg(aw_addr_q, `SWTC_OFF_CLEAR) && w_strb_q[0])
         clear_d = w_data_q[3:0];
   end

   // ----------------------------------------------------------------------
   // Write channel: address and data are taken in either order.
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (reset)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SWTC_RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= `SWTC_ZERO32;
         w_strb_q <= 4'h0;
      end
      else
      begin
         s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (is_reg(aw_addr_q, `SWTC_OFF_MODE)
               || is_reg(aw_addr_q, `SWTC_OFF_CLEAR)
               || is_reg(aw_addr_q, `SWTC_OFF_STATUS)
               || is_reg(aw_addr_q, `SWTC_OFF_MASK)) ? `SWTC_RESP_OKAY : `SWTC_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Control registers; each byte lane updates only under its strobe.
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (reset)
      begin
         for (i = 0; i < `SWTC_NSRC; i = i + 1)
            sel_q[i] <= `SWTC_SEL_RST;
         en_q <= 4'h0;
         mask_q <= 4'h0;
      end
      else if (do_write)
      begin
         for (i = 0; i < `SWTC_NSRC; i = i + 1)
         begin
            if (is_reg(aw_addr_q, `SWTC_OFF_MODE) && w_strb_q[i])
            begin
               // Written as given; trigger and enable of a lane change together in one write.
               sel_q[i] <= lane(w_data_q, i[1:0]);
               en_q[i] <= w_data_q[i*`SWTC_LANE_W + `SWTC_EN_BIT];
            end
         end
         if (is_reg(aw_addr_q, `SWTC_OFF_MASK) && w_strb_q[0])
            mask_q <= w_data_q[3:0];
      end
   end

   // ----------------------------------------------------------------------
   // Sticky wake status, write one to clear; a new wake wins over clear.
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (reset)
      begin
         status_q <= 4'h0;
         irq_q <= 1'b0;
         wake_request_q <= 4'h0;
      end
      else
      begin
         status_q <= (status_q & ~clear_d) | wake;
         irq_q <= |(status_q & mask_q);
         wake_request_q <= wake;
      end
   end

   // ----------------------------------------------------------------------
   // Read channel: one-cycle accept, data one cycle later.
   // ----------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (reset)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `SWTC_ZERO32;
         s_axi_rresp <= `SWTC_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SWTC_RESP_OKAY;
            if (is_reg(s_axi_araddr, `SWTC_OFF_MODE))
               s_axi_rdata <= mode_rd;
            else if (is_reg(s_axi_araddr, `SWTC_OFF_STATUS))
               s_axi_rdata <= {28'h000_0000, status_q};
            else if (is_reg(s_axi_araddr, `SWTC_OFF_MASK))
               s_axi_rdata <= {28'h000_0000, mask_q};
            else if (is_reg(s_axi_araddr, `SWTC_OFF_CLEAR))
               s_axi_rdata <= `SWTC_ZERO32;
            else
            begin
               s_axi_rdata <= `SWTC_ZERO32;
               s_axi_rresp <= `SWTC_RESP_SLVERR;
            end
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // swtc_top

//--- sim/swtc_pin_model.sv
/*
 Far-side model of the four external wake pins of sources 4 to 7.
 Assumes the bench sets the wanted levels; pins move a little after the edge.
*/
`timescale 1ns/10ps

module swtc_pin_model
(
   input wire clk,
   input wire [3:0] level,
   output reg [3:0] ext_irq_pins
);
   // Source 6 starts high, so that a falling edge can be shown later.
   initial ext_irq_pins = 4'h4;

   // The delay keeps the pins asynchronous to the sampling edge.
   always @(posedge clk)
      ext_irq_pins <= #7 level;
endmodule // swtc_pin_model

//--- sim/swtc_chk.sv
/*
 Checker of the register bus handshakes, quiet wake after reset and interrupt timing.
 Assumes it is bound into swtc_top, one clock, synchronous reset.
*/
`timescale 1ns/10ps

module swtc_chk
(
   input wire clk,
   input wire reset,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire [3:0] wake_request_q,
   input wire irq_q
);
   // ---------------------------------------------------------------
   // Properties.
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // A read address taken by the slave.
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   // Remembers taken write data until the response that it earns starts.
   reg w_seen_q;
   always @(posedge clk)
   begin
      if (reset)
         w_seen_q <= 1'b0;
      else if (s_axi_wready)
         w_seen_q <= 1'b1;
      else if (s_axi_bvalid)
         w_seen_q <= 1'b0;
   end

   a_release_quiet: assert property ($fell(reset) |-> !irq_q && wake_request_q == 4'h0)
      else $error("wake or irq active after reset");
   a_release_idle: assert property ($fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid)
      else $error("bus answer active after reset");
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   a_ar_answer: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read data late");
   a_b_after_w: assert property ($rose(s_axi_bvalid) |-> w_seen_q)
      else $error("write response without data");
   a_irq_cause: assert property ($rose(irq_q) |-> $past(|wake_request_q) ||
      $past(s_axi_bvalid) || $past(s_axi_wready, 2))
      else $error("irq rose without wake or mask write");
endmodule // swtc_chk

bind swtc_top swtc_chk chk
(
   .clk(clk),
   .reset(reset),
   .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp),
   .wake_request_q(wake_request_q),
   .irq_q(irq_q)
);

//--- sim/test_standby_wake_trigger_config.sv
/*
 Register-level bench of the standby wake trigger block.
 Assumes swtc_top, the pin model and the checker bound into the top.
*/
`timescale 1ns/10ps
`include "swtc_defs.vh"

module test_standby_wake_trigger_config;
   reg clk, reset, awvalid, wvalid, bready, arvalid, rready, got;
   reg [3:0] awaddr, araddr, wstrb, lvl, seen;
   reg [31:0] wdata;
   wire [3:0] pins, wake;
   wire [31:0] rdata;
   wire [1:0] bresp, rresp;
   wire awready, wready, bvalid, arready, rvalid, irq;
   integer n_fail, n_tests, i;

   swtc_pin_model pm (.clk(clk), .level(lvl), .ext_irq_pins(pins));
   swtc_top dut (.clk(clk), .reset(reset), .ext_irq_pins(pins), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .wake_request_q(wake), .irq_q(irq));

   // Wake pulses last one cycle, so they are gathered here for later checks.
   always @(posedge clk)
      seen <= reset ? 4'h0 : seen | wake;

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task check(input [31:0] s, input [31:0] e);
      begin
         n_tests = n_tests + 1;
         if (s !== e)
         begin
            n_fail = n_fail + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask

   // Address and data are offered together; each is dropped once taken.
   task wr(input [3:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= d;
         wstrb <= s;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         got = 1'b0;
         while (!got)
         begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            got = bvalid;
         end
         bready <= 1'b0;
         check({30'h0, bresp}, {30'h0, er});
      end
   endtask

   task rd(input [3:0] a, input [31:0] e, input [1:0] er);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         got = 1'b0;
         while (!got)
         begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            got = rvalid;
         end
         rready <= 1'b0;
         check(rdata, e);
         check({30'h0, rresp}, {30'h0, er});
      end
   endtask

   task report_and_stop;
      begin
         $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   // The tests take under two hundred cycles; this bounds any hang.
   initial
   begin
      repeat (4000) @(posedge clk);
      n_fail = n_fail + 1;
      report_and_stop;
   end

   // Reset, then the scenarios in order.
   initial
   begin
      n_fail = 0;
      n_tests = 0;
      {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h21;
      {awaddr, araddr, wstrb, wdata} = 44'h0;
      rready = 1'b0;
      lvl = 4'h4;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd(`SWTC_OFF_MODE, 32'h2020_2020, `SWTC_RESP_OKAY);
      rd(`SWTC_OFF_STATUS, `SWTC_ZERO32, `SWTC_RESP_OKAY);
      rd(4'h2, `SWTC_ZERO32, `SWTC_RESP_SLVERR);
      wr(4'h2, 32'hFFFF_FFFF, 4'hF, `SWTC_RESP_SLVERR);
      rd(`SWTC_OFF_MODE, 32'h2020_2020, `SWTC_RESP_OKAY);
      // Every trigger code in every lane; the enables stay off meanwhile.
      for (i = 0; i < 5; i = i + 1)
      begin
         wr(`SWTC_OFF_MODE, {4{1'b0, i[2:0], 4'h0}}, 4'hF, `SWTC_RESP_OKAY);
         rd(`SWTC_OFF_MODE, {4{1'b0, i[2:0], 4'h0}}, `SWTC_RESP_OKAY);
      end
      wr(`SWTC_OFF_MODE, 32'h4141_4141, 4'hF, `SWTC_RESP_OKAY);
      wr(`SWTC_OFF_MASK, 32'h0000_000F, 4'h1, `SWTC_RESP_OKAY);
      // Rise on 4 and 7, fall on 6, nothing on 5.
      lvl <= 4'h9;
      repeat (8) @(posedge clk);
      rd(`SWTC_OFF_MODE, 32'h4549_4145, `SWTC_RESP_OKAY);
      rd(`SWTC_OFF_STATUS, 32'h0000_000D, `SWTC_RESP_OKAY);
      check({28'h0, seen}, 32'h0000_000D);
      check({31'h0, irq}, 32'h0000_0001);
      lvl <= 4'h0;
      repeat (8) @(posedge clk);
      rd(`SWTC_OFF_MODE, 32'h4D49_414D, `SWTC_RESP_OKAY);
      wr(`SWTC_OFF_CLEAR, 32'h0000_000F, 4'h1, `SWTC_RESP_OKAY);
      rd(`SWTC_OFF_MODE, 32'h4141_4141, `SWTC_RESP_OKAY);
      rd(`SWTC_OFF_STATUS, `SWTC_ZERO32, `SWTC_RESP_OKAY);
      check({31'h0, irq}, `SWTC_ZERO32);
      // Source 4 blocked and the mask closed; then the mask opens.
      wr(`SWTC_OFF_MASK, `SWTC_ZERO32, 4'h1, `SWTC_RESP_OKAY);
      wr(`SWTC_OFF_MODE, 32'h0000_0040, 4'h1, `SWTC_RESP_OKAY);
      lvl <= 4'h3;
      repeat (8) @(posedge clk);
      rd(`SWTC_OFF_STATUS, 32'h0000_0002, `SWTC_RESP_OKAY);
      check({31'h0, irq}, `SWTC_ZERO32);
      wr(`SWTC_OFF_MASK, 32'h0000_0002, 4'h1, `SWTC_RESP_OKAY);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0000_0001);
      report_and_stop;
   end
endmodule // test_standby_wake_trigger_config
